// >>> logic/crfc_pkg.sv
// Constants shared by the core register set and its arithmetic unit
package crfc_pkg;
   // Condition flag bit positions
   localparam int FLAG_STOP_DIS = 7;
   localparam int FLAG_PIN_NONMASKABLE_IRQ_MASK = 6;
   localparam int FLAG_HALF = 5;
   localparam int FLAG_IRQ_MASK = 4;
   localparam int FLAG_NEG = 3;
   localparam int FLAG_ZERO = 2;
   localparam int FLAG_OVF = 1;
   localparam int FLAG_CARRY = 0;
   localparam logic [7:0] FLAGS_RESET = 8'hD0;
   // Register selects on the access port
   localparam logic [2:0] SEL_ACC_HIGH = 3'h0;
   localparam logic [2:0] SEL_ACC_LOW = 3'h1;
   localparam logic [2:0] SEL_DOUBLE = 3'h2;
   localparam logic [2:0] SEL_INDEX_FIRST = 3'h3;
   localparam logic [2:0] SEL_INDEX_SECOND = 3'h4;
   localparam logic [2:0] SEL_STACK = 3'h5;
   localparam logic [2:0] SEL_PC = 3'h6;
   localparam logic [2:0] SEL_FLAGS = 3'h7;
   // Arithmetic operations
   localparam logic [3:0] OP_ADD_A = 4'h0;
   localparam logic [3:0] OP_ADC_A = 4'h1;
   localparam logic [3:0] OP_ADD_ACCUMULATORS = 4'h2;
   localparam logic [3:0] OP_SUB_A = 4'h3;
   localparam logic [3:0] OP_DECIMAL_ADJUST = 4'h4;
   localparam logic [3:0] OP_ADD_D = 4'h5;
   localparam logic [3:0] OP_SUB_D = 4'h6;
   // Base register codes for indexed addressing
   localparam logic [1:0] BASE_INDEX_FIRST = 2'h0;
   localparam logic [1:0] BASE_INDEX_SECOND = 2'h1;
   localparam logic [1:0] BASE_STACK = 2'h2;
   localparam logic [1:0] BASE_PC = 2'h3;
   // Offset modes for indexed addressing
   localparam logic [2:0] EA_CONST = 3'h0;
   localparam logic [2:0] EA_ACC_HIGH = 3'h1;
   localparam logic [2:0] EA_ACC_LOW = 3'h2;
   localparam logic [2:0] EA_DOUBLE = 3'h3;
   localparam logic [2:0] EA_AUTO_PRE = 3'h4;
   localparam logic [2:0] EA_AUTO_POST = 3'h5;
   // Arithmetic constants
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [3:0] BCD_DIGIT_HIGH = 4'h8;
   localparam logic [7:0] BCD_ADJ_LOW = 8'h06;
   localparam logic [7:0] BCD_ADJ_HIGH = 8'h60;
   localparam logic [15:0] WORD_BYTES = 16'h0002;
   localparam logic [15:0] NEXT_BYTE = 16'h0001;
endpackage

// >>> logic/crfc_alu.sv
// Combinational arithmetic unit producing results and condition flags
`timescale 1ns/10ps
module crfc_alu (
   input wire logic [3:0] op,
   input wire logic [7:0] acc_high,
   input wire logic [7:0] acc_low,
   input wire logic [15:0] operand,
   input wire logic [7:0] flags_in,
   output logic [15:0] result,
   output logic [7:0] flags_out,
   output logic to_double
);
   always_comb
   begin
      logic [8:0] sum8;
      logic [16:0] sum16;
      logic [4:0] nib;
      logic [7:0] opb;
      logic [15:0] dbl;
      logic cin;
      logic adj_high;
      sum8 = '0;
      sum16 = '0;
      nib = '0;
      dbl = {acc_high, acc_low};
      opb = (op == crfc_pkg::OP_ADD_ACCUMULATORS) ? acc_low : operand[7:0];
      cin = (op == crfc_pkg::OP_ADC_A) ? flags_in[crfc_pkg::FLAG_CARRY] : 1'b0;
      adj_high = 1'b0;
      result = dbl;
      flags_out = flags_in;
      to_double = 1'b0;
      case (op)
         crfc_pkg::OP_ADD_A, crfc_pkg::OP_ADC_A, crfc_pkg::OP_ADD_ACCUMULATORS:
         begin
            sum8 = {1'b0, acc_high} + {1'b0, opb} + {8'h00, cin};
            nib = {1'b0, acc_high[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
            flags_out[crfc_pkg::FLAG_HALF] = nib[4];
            flags_out[crfc_pkg::FLAG_OVF] = (acc_high[7] == opb[7]) && (sum8[7] != acc_high[7]);
         end
         crfc_pkg::OP_SUB_A:
         begin
            sum8 = {1'b0, acc_high} - {1'b0, opb};
            flags_out[crfc_pkg::FLAG_OVF] = (acc_high[7] != opb[7]) && (sum8[7] != acc_high[7]);
         end
         crfc_pkg::OP_DECIMAL_ADJUST:
         begin
            adj_high = flags_in[crfc_pkg::FLAG_CARRY] || (acc_high[7:4] > crfc_pkg::BCD_DIGIT_MAX)
               || ((acc_high[7:4] > crfc_pkg::BCD_DIGIT_HIGH)
               && (acc_high[3:0] > crfc_pkg::BCD_DIGIT_MAX));
            sum8 = {1'b0, acc_high}
               + {1'b0, (flags_in[crfc_pkg::FLAG_HALF] || (acc_high[3:0] > crfc_pkg::BCD_DIGIT_MAX))
                  ? crfc_pkg::BCD_ADJ_LOW : 8'h00}
               + {1'b0, adj_high ? crfc_pkg::BCD_ADJ_HIGH : 8'h00};
         end
         crfc_pkg::OP_ADD_D, crfc_pkg::OP_SUB_D:
         begin
            to_double = 1'b1;
            if (op == crfc_pkg::OP_ADD_D)
            begin
               sum16 = {1'b0, dbl} + {1'b0, operand};
               flags_out[crfc_pkg::FLAG_OVF] = (dbl[15] == operand[15]) && (sum16[15] != dbl[15]);
            end
            else
            begin
               sum16 = {1'b0, dbl} - {1'b0, operand};
               flags_out[crfc_pkg::FLAG_OVF] = (dbl[15] != operand[15]) && (sum16[15] != dbl[15]);
            end
            result = sum16[15:0];
            flags_out[crfc_pkg::FLAG_CARRY] = sum16[16];
            flags_out[crfc_pkg::FLAG_NEG] = sum16[15];
            flags_out[crfc_pkg::FLAG_ZERO] = (sum16[15:0] == 16'h0000);
         end
         default:
         begin
            result = dbl;
         end
      endcase
      if (!to_double && (op <= crfc_pkg::OP_DECIMAL_ADJUST))
      begin
         result = {sum8[7:0], acc_low};
         flags_out[crfc_pkg::FLAG_NEG] = sum8[7];
         flags_out[crfc_pkg::FLAG_ZERO] = (sum8[7:0] == 8'h00);
         // Decimal adjust keeps a carry it already had
         flags_out[crfc_pkg::FLAG_CARRY] = (op == crfc_pkg::OP_DECIMAL_ADJUST)
            ? (adj_high || sum8[8]) : sum8[8];
      end
   end
endmodule // crfc_alu

// >>> logic/crfc_core_regs.sv
// Programmer-visible register set, condition flags and address forming
`timescale 1ns/10ps
module crfc_core_regs (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [2:0] reg_sel,
   input wire logic [15:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [15:0] rd_data,
   input wire logic alu_en,
   input wire logic [3:0] alu_op,
   input wire logic [15:0] alu_operand,
   input wire logic ea_req,
   input wire logic [1:0] ea_base,
   input wire logic [2:0] ea_mode,
   input wire logic [15:0] ea_offset,
   output logic ea_valid,
   output logic ea_illegal,
   output logic [15:0] ea_addr,
   output logic [15:0] ea_addr_next,
   input wire logic push_req,
   input wire logic [15:0] push_data,
   input wire logic pull_req,
   output logic stk_valid,
   output logic [15:0] stk_addr_hi,
   output logic [15:0] stk_addr_lo,
   output logic [7:0] stk_byte_hi,
   output logic [7:0] stk_byte_lo,
   input wire logic pc_step,
   input wire logic [2:0] pc_len,
   output logic [15:0] program_counter,
   input wire logic stop_req,
   output logic stop_enter,
   output logic stop_ignored,
   input wire logic pin_nonmaskable_irq_n,
   input wire logic irq_req,
   output logic pin_nonmaskable_irq_service,
   output logic irq_service,
   output logic [7:0] condition_flags
);
   typedef struct packed {
      logic [7:0] accumulator_high;
      logic [7:0] accumulator_low;
      logic [15:0] index_first;
      logic [15:0] index_second;
      logic [15:0] stack_pointer;
      logic [15:0] program_counter;
      logic [7:0] condition_flags;
      logic pin_nonmaskable_irq_meta;
      logic pin_nonmaskable_irq_sync;
      logic [15:0] rd_data;
      logic ea_valid;
      logic ea_illegal;
      logic [15:0] ea_addr;
      logic [15:0] ea_addr_next;
      logic stk_valid;
      logic [15:0] stk_addr_hi;
      logic [15:0] stk_addr_lo;
      logic [7:0] stk_byte_hi;
      logic [7:0] stk_byte_lo;
      logic stop_enter;
      logic stop_ignored;
      logic pin_nonmaskable_irq_service;
      logic irq_service;
   } crfc_state_t;

   crfc_state_t st;
   crfc_state_t next_st;
   logic [15:0] alu_result;
   logic [7:0] alu_flags;
   logic alu_double;
   logic [15:0] base_val;
   logic [15:0] offset_val;
   logic auto_mode;

   crfc_alu u_alu (
      .op(alu_op),
      .acc_high(st.accumulator_high),
      .acc_low(st.accumulator_low),
      .operand(alu_operand),
      .flags_in(st.condition_flags),
      .result(alu_result),
      .flags_out(alu_flags),
      .to_double(alu_double)
   );

   always_comb
   begin
      unique case (ea_base)
         crfc_pkg::BASE_INDEX_FIRST: base_val = st.index_first;
         crfc_pkg::BASE_INDEX_SECOND: base_val = st.index_second;
         crfc_pkg::BASE_STACK: base_val = st.stack_pointer;
         crfc_pkg::BASE_PC: base_val = st.program_counter;
      endcase
      // Accumulator offsets are unsigned
      case (ea_mode)
         crfc_pkg::EA_ACC_HIGH: offset_val = {8'h00, st.accumulator_high};
         crfc_pkg::EA_ACC_LOW: offset_val = {8'h00, st.accumulator_low};
         crfc_pkg::EA_DOUBLE: offset_val = {st.accumulator_high, st.accumulator_low};
         default: offset_val = ea_offset;
      endcase
      auto_mode = (ea_mode == crfc_pkg::EA_AUTO_PRE) || (ea_mode == crfc_pkg::EA_AUTO_POST);
   end

   always_comb
   begin
      next_st = st;
      next_st.pin_nonmaskable_irq_meta = ~pin_nonmaskable_irq_n;
      next_st.pin_nonmaskable_irq_sync = st.pin_nonmaskable_irq_meta;
      next_st.rd_data = 16'h0000;
      next_st.ea_valid = 1'b0;
      next_st.ea_illegal = 1'b0;
      next_st.stk_valid = 1'b0;
      next_st.stop_enter = 1'b0;
      next_st.stop_ignored = 1'b0;
      // Only the second synchroniser stage feeds logic
      next_st.pin_nonmaskable_irq_service = st.pin_nonmaskable_irq_sync && !st.condition_flags[crfc_pkg::FLAG_PIN_NONMASKABLE_IRQ_MASK];
      next_st.irq_service = irq_req && !st.condition_flags[crfc_pkg::FLAG_IRQ_MASK];
      if (stop_req)
      begin
         next_st.stop_enter = !st.condition_flags[crfc_pkg::FLAG_STOP_DIS];
         next_st.stop_ignored = st.condition_flags[crfc_pkg::FLAG_STOP_DIS];
      end
      // Later blocks override earlier ones: write beats alu beats auto update
      // Auto update beats push, push beats pull, pull beats pc step
      if (pc_step)
      begin
         next_st.program_counter = st.program_counter + {13'h0000, pc_len};
      end
      if (pull_req)
      begin
         next_st.stack_pointer = st.stack_pointer + crfc_pkg::WORD_BYTES;
      end
      if (push_req)
      begin
         // Pre-decrement keeps the pointer on the last byte written
         next_st.stack_pointer = st.stack_pointer - crfc_pkg::WORD_BYTES;
         next_st.stk_valid = 1'b1;
         next_st.stk_addr_hi = st.stack_pointer - crfc_pkg::WORD_BYTES;
         next_st.stk_addr_lo = st.stack_pointer - crfc_pkg::NEXT_BYTE;
         next_st.stk_byte_hi = push_data[15:8];
         next_st.stk_byte_lo = push_data[7:0];
      end
      if (ea_req)
      begin
         if (auto_mode && (ea_base == crfc_pkg::BASE_PC))
         begin
            next_st.ea_illegal = 1'b1;
         end
         else
         begin
            next_st.ea_valid = 1'b1;
            // Any byte address is legal; no alignment check
            next_st.ea_addr = (ea_mode == crfc_pkg::EA_AUTO_POST) ? base_val
               : base_val + offset_val;
            next_st.ea_addr_next = next_st.ea_addr + crfc_pkg::NEXT_BYTE;
            if (auto_mode)
            begin
               unique case (ea_base)
                  crfc_pkg::BASE_INDEX_FIRST: next_st.index_first = base_val + offset_val;
                  crfc_pkg::BASE_INDEX_SECOND: next_st.index_second = base_val + offset_val;
                  crfc_pkg::BASE_STACK: next_st.stack_pointer = base_val + offset_val;
                  crfc_pkg::BASE_PC: next_st.program_counter = st.program_counter;
               endcase
            end
         end
      end
      if (alu_en)
      begin
         next_st.condition_flags = alu_flags;
         next_st.accumulator_high = alu_result[15:8];
         if (alu_double)
         begin
            next_st.accumulator_low = alu_result[7:0];
         end
      end
      if (wr_en)
      begin
         unique case (reg_sel)
            crfc_pkg::SEL_ACC_HIGH: next_st.accumulator_high = wr_data[7:0];
            crfc_pkg::SEL_ACC_LOW: next_st.accumulator_low = wr_data[7:0];
            crfc_pkg::SEL_DOUBLE:
            begin
               next_st.accumulator_high = wr_data[15:8];
               next_st.accumulator_low = wr_data[7:0];
            end
            crfc_pkg::SEL_INDEX_FIRST: next_st.index_first = wr_data;
            crfc_pkg::SEL_INDEX_SECOND: next_st.index_second = wr_data;
            crfc_pkg::SEL_STACK: next_st.stack_pointer = wr_data;
            crfc_pkg::SEL_PC: next_st.program_counter = wr_data;
            crfc_pkg::SEL_FLAGS: next_st.condition_flags = wr_data[7:0];
         endcase
      end
      // Reads see values from before a same-cycle write
      if (rd_en)
      begin
         unique case (reg_sel)
            crfc_pkg::SEL_ACC_HIGH: next_st.rd_data = {8'h00, st.accumulator_high};
            crfc_pkg::SEL_ACC_LOW: next_st.rd_data = {8'h00, st.accumulator_low};
            crfc_pkg::SEL_DOUBLE: next_st.rd_data = {st.accumulator_high, st.accumulator_low};
            crfc_pkg::SEL_INDEX_FIRST: next_st.rd_data = st.index_first;
            crfc_pkg::SEL_INDEX_SECOND: next_st.rd_data = st.index_second;
            crfc_pkg::SEL_STACK: next_st.rd_data = st.stack_pointer;
            crfc_pkg::SEL_PC: next_st.rd_data = st.program_counter;
            crfc_pkg::SEL_FLAGS: next_st.rd_data = {8'h00, st.condition_flags};
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st <= '0;
         st.condition_flags <= crfc_pkg::FLAGS_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign rd_data = st.rd_data;
   assign ea_valid = st.ea_valid;
   assign ea_illegal = st.ea_illegal;
   assign ea_addr = st.ea_addr;
   assign ea_addr_next = st.ea_addr_next;
   assign stk_valid = st.stk_valid;
   assign stk_addr_hi = st.stk_addr_hi;
   assign stk_addr_lo = st.stk_addr_lo;
   assign stk_byte_hi = st.stk_byte_hi;
   assign stk_byte_lo = st.stk_byte_lo;
   assign program_counter = st.program_counter;
   assign stop_enter = st.stop_enter;
   assign stop_ignored = st.stop_ignored;
   assign pin_nonmaskable_irq_service = st.pin_nonmaskable_irq_service;
   assign irq_service = st.irq_service;
   assign condition_flags = st.condition_flags;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic solo_alu;
   assign solo_alu = alu_en && !wr_en && !ea_req;

   a_double_view: assert property (rd_en && reg_sel == crfc_pkg::SEL_DOUBLE && !wr_en
      |=> rd_data == {$past(st.accumulator_high), $past(st.accumulator_low)})
      else $error("double accumulator read does not match its halves");
   a_stop_ignore: assert property (stop_req && st.condition_flags[crfc_pkg::FLAG_STOP_DIS]
      |=> stop_ignored && !stop_enter)
      else $error("stop taken while disabled");
   a_pin_nonmaskable_irq_mask: assert property (pin_nonmaskable_irq_service
      |-> !$past(st.condition_flags[crfc_pkg::FLAG_PIN_NONMASKABLE_IRQ_MASK]))
      else $error("pin request serviced while masked");
   a_irq_mask: assert property (irq_service
      |-> $past(irq_req) && !$past(st.condition_flags[crfc_pkg::FLAG_IRQ_MASK]))
      else $error("maskable request serviced while masked");
   a_half_carry: assert property (solo_alu && alu_op == crfc_pkg::OP_ADD_A
      |=> condition_flags[crfc_pkg::FLAG_HALF]
         == (5'({1'b0, $past(st.accumulator_high[3:0])})
            + 5'({1'b0, $past(alu_operand[3:0])}) > 5'h0F))
      else $error("half carry wrong after add");
   a_zero_neg: assert property (solo_alu && alu_op == crfc_pkg::OP_SUB_A
      |=> condition_flags[crfc_pkg::FLAG_ZERO] == (st.accumulator_high == 8'h00)
         && condition_flags[crfc_pkg::FLAG_NEG] == st.accumulator_high[7])
      else $error("zero or negative flag wrong");
   a_half_kept: assert property (solo_alu && alu_op == crfc_pkg::OP_SUB_A
      |=> $stable(condition_flags[crfc_pkg::FLAG_HALF]))
      else $error("half carry changed by subtract");
   a_pc_auto: assert property (ea_req && ea_base == crfc_pkg::BASE_PC
      && (ea_mode == crfc_pkg::EA_AUTO_PRE || ea_mode == crfc_pkg::EA_AUTO_POST) && !wr_en
      |=> ea_illegal && !ea_valid && $stable(program_counter))
      else $error("program counter accepted in auto mode");
   a_ea_const: assert property (ea_req && ea_mode == crfc_pkg::EA_CONST
      && ea_base == crfc_pkg::BASE_INDEX_FIRST
      |=> ea_valid && ea_addr == $past(st.index_first) + $past(ea_offset)
         && ea_addr_next == ea_addr + crfc_pkg::NEXT_BYTE)
      else $error("constant offset address wrong");
   a_push_order: assert property (push_req && !pull_req && !wr_en && !ea_req
      |=> stk_valid && stk_byte_hi == $past(push_data[15:8])
         && stk_addr_hi == st.stack_pointer && stk_addr_lo == stk_addr_hi + crfc_pkg::NEXT_BYTE)
      else $error("stack push order wrong");

   // Read data stand for one cycle only, then drop to zero
   a_read_idle: assert property (!rd_en
      |=> rd_data == 16'h0000)
      else $error("read data present without a read");
   a_pull_step: assert property (pull_req && !push_req && !wr_en && !ea_req
      |=> st.stack_pointer == $past(st.stack_pointer) + crfc_pkg::WORD_BYTES)
      else $error("stack pointer not raised by pull");
   a_pc_step: assert property (pc_step && !wr_en && !ea_req && !push_req && !pull_req
      |=> program_counter == $past(program_counter) + {13'h0000, $past(pc_len)})
      else $error("program counter step wrong");
   // Byte operations must leave the low accumulator alone
   a_acc_low_kept: assert property (solo_alu && alu_op <= crfc_pkg::OP_DECIMAL_ADJUST
      |=> $stable(st.accumulator_low))
      else $error("low accumulator changed by byte operation");
   a_write_double: assert property (wr_en && reg_sel == crfc_pkg::SEL_DOUBLE
      |=> {st.accumulator_high, st.accumulator_low} == $past(wr_data))
      else $error("double write did not reach both halves");
   a_index_store: assert property (wr_en && reg_sel == crfc_pkg::SEL_INDEX_SECOND
      |=> st.index_second == $past(wr_data))
      else $error("index register did not store data");
   a_stop_enter: assert property (stop_req && !st.condition_flags[crfc_pkg::FLAG_STOP_DIS]
      |=> stop_enter && !stop_ignored)
      else $error("stop not entered while enabled");

   c_push: cover property (push_req ##1 stk_valid);
   c_stop_ignored: cover property (stop_ignored);
   c_daa: cover property (alu_en && alu_op == crfc_pkg::OP_DECIMAL_ADJUST);
   c_auto_post: cover property (ea_req && ea_mode == crfc_pkg::EA_AUTO_POST ##1 ea_valid);
   c_pc_refused: cover property (ea_req && ea_base == crfc_pkg::BASE_PC ##1 ea_illegal);
endmodule // crfc_core_regs

// >>> tb/crfc_core_regs_tb.sv
// Self-checking testbench for the core register set
`timescale 1ns/10ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
   logic clk;
   logic resetn;
   logic [2:0] reg_sel;
   logic [15:0] wr_data;
   logic wr_en;
   logic rd_en;
   logic [15:0] rd_data;
   logic alu_en;
   logic [3:0] alu_op;
   logic [15:0] alu_operand;
   logic ea_req;
   logic [1:0] ea_base;
   logic [2:0] ea_mode;
   logic [15:0] ea_offset;
   logic ea_valid;
   logic ea_illegal;
   logic [15:0] ea_addr;
   logic [15:0] ea_addr_next;
   logic push_req;
   logic [15:0] push_data;
   logic pull_req;
   logic stk_valid;
   logic [15:0] stk_addr_hi;
   logic [15:0] stk_addr_lo;
   logic [7:0] stk_byte_hi;
   logic [7:0] stk_byte_lo;
   logic pc_step;
   logic [2:0] pc_len;
   logic [15:0] program_counter;
   logic stop_req;
   logic stop_enter;
   logic stop_ignored;
   logic pin_nonmaskable_irq_n;
   logic irq_req;
   logic pin_nonmaskable_irq_service;
   logic irq_service;
   logic [7:0] condition_flags;
   int err_total;
   int total_checks;
   // Arithmetic cases: inputs, then expected accumulators and flags
   logic [3:0] c_op [9] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
   logic [7:0] c_a [9] = '{8'h0F, 8'h7F, 8'hFF, 8'h12, 8'h00, 8'h11, 8'hFF, 8'h80, 8'h5A};
   logic [7:0] c_b [9] = '{8'h00, 8'h00, 8'h00, 8'h34, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
   logic [7:0] c_f [9] = '{8'h00, 8'h00, 8'h01, 8'h80, 8'h20, 8'h20, 8'h00, 8'h00, 8'hC3};
   logic [15:0] c_opd [9] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0001, 16'h0000,
      16'h0001, 16'h0001, 16'h0000};
   logic [7:0] x_a [9] = '{8'h10, 8'h80, 8'h00, 8'h46, 8'hFF, 8'h17, 8'h00, 8'h7F, 8'h5A};
   logic [7:0] x_b [9] = '{8'h00, 8'h00, 8'h00, 8'h34, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
   logic [7:0] x_f [9] = '{8'h20, 8'h2A, 8'h25, 8'h80, 8'h29, 8'h20, 8'h05, 8'h02, 8'hC3};

   crfc_core_regs u_crfc_core_regs (
      .clk(clk), .resetn(resetn), .reg_sel(reg_sel), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .alu_en(alu_en), .alu_op(alu_op),
      .alu_operand(alu_operand), .ea_req(ea_req), .ea_base(ea_base), .ea_mode(ea_mode),
      .ea_offset(ea_offset), .ea_valid(ea_valid), .ea_illegal(ea_illegal), .ea_addr(ea_addr),
      .ea_addr_next(ea_addr_next), .push_req(push_req), .push_data(push_data),
      .pull_req(pull_req), .stk_valid(stk_valid), .stk_addr_hi(stk_addr_hi),
      .stk_addr_lo(stk_addr_lo), .stk_byte_hi(stk_byte_hi), .stk_byte_lo(stk_byte_lo),
      .pc_step(pc_step), .pc_len(pc_len), .program_counter(program_counter),
      .stop_req(stop_req), .stop_enter(stop_enter), .stop_ignored(stop_ignored),
      .pin_nonmaskable_irq_n(pin_nonmaskable_irq_n), .irq_req(irq_req),
      .pin_nonmaskable_irq_service(pin_nonmaskable_irq_service), .irq_service(irq_service),
      .condition_flags(condition_flags)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic wr(input logic [2:0] sel, input logic [15:0] d);
      @(posedge clk);
      reg_sel <= sel;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [2:0] sel, input logic [15:0] exp);
      @(posedge clk);
      reg_sel <= sel;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      `CHK(rd_data, exp)
   endtask

   task automatic ea(input logic [1:0] b, input logic [2:0] m, input logic [15:0] off,
      input logic ok, input logic [15:0] addr);
      @(posedge clk);
      ea_base <= b;
      ea_mode <= m;
      ea_offset <= off;
      ea_req <= 1'b1;
      @(posedge clk);
      ea_req <= 1'b0;
      #1;
      `CHK(ea_valid, ok)
      `CHK(ea_illegal, ~ok)
      if (ok)
      begin
         `CHK(ea_addr, addr)
         `CHK(ea_addr_next, addr + 16'h0001)
      end
   endtask

   task automatic t_reset;
      rdchk(crfc_pkg::SEL_FLAGS, {8'h00, crfc_pkg::FLAGS_RESET});
      `CHK(program_counter, 16'h0000)
      $display("t_reset done");
   endtask

   task automatic t_regs;
      wr(crfc_pkg::SEL_ACC_HIGH, 16'h0012);
      wr(crfc_pkg::SEL_ACC_LOW, 16'h0034);
      rdchk(crfc_pkg::SEL_ACC_HIGH, 16'h0012);
      rdchk(crfc_pkg::SEL_DOUBLE, 16'h1234);
      wr(crfc_pkg::SEL_DOUBLE, 16'hABCD);
      rdchk(crfc_pkg::SEL_ACC_HIGH, 16'h00AB);
      rdchk(crfc_pkg::SEL_ACC_LOW, 16'h00CD);
      for (int k = 3; k < 7; k++)
         wr(k[2:0], {k[3:0], 12'h5A3});
      for (int k = 3; k < 7; k++)
         rdchk(k[2:0], {k[3:0], 12'h5A3});
      $display("t_regs done");
   endtask

   // Flags are preset for each case so kept bits show up
   task automatic t_alu;
      for (int i = 0; i < 9; i++)
      begin
         wr(crfc_pkg::SEL_ACC_HIGH, {8'h00, c_a[i]});
         wr(crfc_pkg::SEL_ACC_LOW, {8'h00, c_b[i]});
         wr(crfc_pkg::SEL_FLAGS, {8'h00, c_f[i]});
         @(posedge clk);
         alu_op <= c_op[i];
         alu_operand <= c_opd[i];
         alu_en <= 1'b1;
         @(posedge clk);
         alu_en <= 1'b0;
         rdchk(crfc_pkg::SEL_ACC_HIGH, {8'h00, x_a[i]});
         rdchk(crfc_pkg::SEL_ACC_LOW, {8'h00, x_b[i]});
         rdchk(crfc_pkg::SEL_FLAGS, {8'h00, x_f[i]});
      end
      $display("t_alu done");
   endtask

   task automatic t_ea;
      wr(crfc_pkg::SEL_INDEX_FIRST, 16'h1000);
      wr(crfc_pkg::SEL_INDEX_SECOND, 16'h2000);
      wr(crfc_pkg::SEL_STACK, 16'h3000);
      wr(crfc_pkg::SEL_PC, 16'h4000);
      wr(crfc_pkg::SEL_DOUBLE, 16'h0580);
      ea(crfc_pkg::BASE_INDEX_FIRST, crfc_pkg::EA_CONST, 16'hFFFE, 1'b1, 16'h0FFE);
      ea(crfc_pkg::BASE_INDEX_SECOND, crfc_pkg::EA_ACC_LOW, 16'h0000, 1'b1, 16'h2080);
      ea(crfc_pkg::BASE_STACK, crfc_pkg::EA_DOUBLE, 16'h0000, 1'b1, 16'h3580);
      ea(crfc_pkg::BASE_PC, crfc_pkg::EA_ACC_HIGH, 16'h0000, 1'b1, 16'h4005);
      ea(crfc_pkg::BASE_INDEX_FIRST, crfc_pkg::EA_AUTO_POST, 16'h0002, 1'b1, 16'h1000);
      rdchk(crfc_pkg::SEL_INDEX_FIRST, 16'h1002);
      ea(crfc_pkg::BASE_INDEX_FIRST, crfc_pkg::EA_AUTO_PRE, 16'hFFFF, 1'b1, 16'h1001);
      ea(crfc_pkg::BASE_PC, crfc_pkg::EA_AUTO_PRE, 16'h0001, 1'b0, 16'h0000);
      ea(crfc_pkg::BASE_PC, crfc_pkg::EA_AUTO_POST, 16'h0001, 1'b0, 16'h0000);
      rdchk(crfc_pkg::SEL_PC, 16'h4000);
      $display("t_ea done");
   endtask

   task automatic t_stack_pc;
      @(posedge clk);
      push_data <= 16'hABCD;
      push_req <= 1'b1;
      @(posedge clk);
      push_req <= 1'b0;
      #1;
      `CHK(stk_valid, 1'b1)
      `CHK(stk_addr_hi, 16'h2FFE)
      `CHK(stk_addr_lo, 16'h2FFF)
      `CHK({stk_byte_hi, stk_byte_lo}, 16'hABCD)
      rdchk(crfc_pkg::SEL_STACK, 16'h2FFE);
      @(posedge clk);
      pull_req <= 1'b1;
      @(posedge clk);
      pull_req <= 1'b0;
      rdchk(crfc_pkg::SEL_STACK, 16'h3000);
      @(posedge clk);
      pc_len <= 3'h7;
      pc_step <= 1'b1;
      @(posedge clk);
      pc_step <= 1'b0;
      #1;
      `CHK(program_counter, 16'h4007)
      $display("t_stack_pc done");
   endtask

   task automatic t_stop_irq;
      for (int s = 1; s >= 0; s--)
      begin
         wr(crfc_pkg::SEL_FLAGS, s ? 16'h0080 : 16'h0000);
         @(posedge clk);
         stop_req <= 1'b1;
         @(posedge clk);
         stop_req <= 1'b0;
         #1;
         `CHK({stop_enter, stop_ignored}, s ? 2'b01 : 2'b10)
      end
      @(posedge clk);
      irq_req <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK(irq_service, 1'b1)
      wr(crfc_pkg::SEL_FLAGS, 16'h0010);
      repeat (2) @(posedge clk);
      #1;
      `CHK(irq_service, 1'b0)
      @(posedge clk);
      irq_req <= 1'b0;
      wr(crfc_pkg::SEL_FLAGS, 16'h0000);
      pin_nonmaskable_irq_n <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      `CHK(pin_nonmaskable_irq_service, 1'b1)
      wr(crfc_pkg::SEL_FLAGS, 16'h0040);
      repeat (2) @(posedge clk);
      #1;
      `CHK(pin_nonmaskable_irq_service, 1'b0)
      pin_nonmaskable_irq_n <= 1'b1;
      $display("t_stop_irq done");
   endtask

   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Guard against a hang anywhere in the sequence
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("[FAIL] t=%0t run limit reached", $time);
      wrap_up;
   end

   initial
   begin
      err_total = 0;
      total_checks = 0;
      resetn = 1'b0;
      {reg_sel, wr_data, wr_en, rd_en, alu_en, alu_op, alu_operand} = '0;
      {ea_req, ea_base, ea_mode, ea_offset, push_req, push_data, pull_req} = '0;
      {pc_step, pc_len, stop_req, irq_req} = '0;
      pin_nonmaskable_irq_n = 1'b1;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_regs;
      t_alu;
      t_ea;
      t_stack_pc;
      t_stop_irq;
      wrap_up;
   end
endmodule // tb
